//--- common/rpa_map.vh
`ifndef RPA_MAP_VH
`define RPA_MAP_VH
////////////////////////////////////////////////////////////////////////////////
// register offsets
`define RPA_PORT_SEL_ADDR   8'h4c
`define RPA_TID5_ADDR       8'h62
`define RPA_TID6_ADDR       8'h63
`define RPA_TID7_ADDR       8'h64
`define RPA_ALIAS5_ADDR     8'h6a
`define RPA_ALIAS6_ADDR     8'h6b
`define RPA_ALIAS7_ADDR     8'h6c
`define RPA_CFG_ADDR        8'h6d
////////////////////////////////////////////////////////////////////////////////
// reset values
`define RPA_ALIAS_RST       8'h00
`define RPA_TID_RST         7'h00
`define RPA_PORT_SEL_RST    8'h00
`define RPA_CFG_HI_RST      5'h0f
////////////////////////////////////////////////////////////////////////////////
// field positions
`define RPA_ALIAS_AUTO_ACK  0
`define RPA_CFG_WAIT_FS1    7
`define RPA_CFG_WAIT_FS     6
`define RPA_CFG_PASS_CKSUM  5
`define RPA_CFG_PASS_ECC    4
`define RPA_CFG_LINE_LEN    3
`define RPA_CFG_RSVD        2
////////////////////////////////////////////////////////////////////////////////
// input format codes and first frame-start count
`define RPA_MODE_CSI        2'b00
`define RPA_MODE_RAW12_LF   2'b01
`define RPA_MODE_RAW12_HF   2'b10
`define RPA_MODE_RAW10      2'b11
`define RPA_FIRST_FRAME_CNT 16'h0001
`endif

//--- rtl/rpa_port_cfg.v
// Summary of operation
// - port select steers per-port register access
// - alias entry holds 7-bit address bits 7:1
// - matched transaction forwarded with target address
// - zero alias matches nothing
// - auto-ack bit acknowledges writes locally
// - wait-fs1 bit drops until frame-start count one
// - wait-fs bit drops until frame start
// - raw modes ignore wait and checksum bits
// - bit 5 passes checksum-bad packets
// - bit 4 passes header-ecc-bad packets
// - raw mode bit 3 drops truncated first line
// - csi mode bit 3 passes length-bad packets
// - two-bit field selects input format
`timescale 1ns/1ns
`include "rpa_map.vh"

module rpa_port_cfg (
    input  wire        i_clk,             // 25 MHz clock
    input  wire        i_rst_n,           // synchronous reset, active low
    input  wire [2:0]  i_strap,           // strap pins: [2] reserved bit, [1:0] format
    input  wire        i_reg_wr,          // register write strobe
    input  wire        i_reg_rd,          // register read strobe
    input  wire [7:0]  i_reg_addr,        // register offset
    input  wire [7:0]  i_reg_wdata,       // write data
    output reg  [7:0]  o_reg_rdata,       // read data, one cycle after read strobe
    input  wire        i_txn_valid,       // i2c address phase to decode
    input  wire [6:0]  i_txn_addr,        // 7-bit i2c address
    input  wire        i_txn_write,       // transaction is a write
    output reg         o_fwd_valid,       // decode result valid
    output reg         o_fwd_hit,         // address matched an alias entry
    output reg  [1:0]  o_fwd_port,        // port of the matched entry
    output reg  [6:0]  o_fwd_addr,        // remapped target address
    output reg         o_fwd_auto_ack,    // device acknowledges the write itself
    input  wire        i_pkt_valid,       // packet header from a receive port
    input  wire [1:0]  i_pkt_port,        // receive port of the packet
    input  wire        i_pkt_fs,          // packet is a frame start
    input  wire [15:0] i_pkt_frame_cnt,   // frame count of a frame start
    input  wire        i_pkt_cksum_err,   // checksum error
    input  wire        i_pkt_ecc_err,     // header ecc error
    input  wire        i_pkt_len_err,     // length error
    input  wire        i_pkt_short_line,  // raw: first line missed frame_valid setup
    output reg         o_pkt_valid,       // filter verdict valid
    output reg  [1:0]  o_pkt_port,        // port of the verdict
    output reg         o_pkt_pass         // packet forwarded
);

    // per-port frame-start gating
    localparam ST_WAIT_FS1 = 3'b001;
    localparam ST_WAIT_FS  = 3'b010;
    localparam ST_RUN      = 3'b100;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function is_raw;
        input [1:0] link_input_format;
        begin
            is_raw = (link_input_format != `RPA_MODE_CSI);
        end
    endfunction

    function [2:0] arm_state;
        input [7:0] cfg;
        begin
            if (is_raw(cfg[1:0])) begin
                arm_state = ST_RUN;
            end else if (cfg[`RPA_CFG_WAIT_FS1]) begin
                arm_state = ST_WAIT_FS1;
            end else if (cfg[`RPA_CFG_WAIT_FS]) begin
                arm_state = ST_WAIT_FS;
            end else begin
                arm_state = ST_RUN;
            end
        end
    endfunction

    // entries sit three to a port, port-major
    function [3:0] ent_index;
        input [1:0] port;
        input [1:0] ent;
        begin
            ent_index = {1'b0, port, 1'b0} + {2'b00, port} + {2'b00, ent};
        end
    endfunction

    function [1:0] ent_port;
        input integer idx;
        integer       q;
        begin
            q        = idx / 3;
            ent_port = q[1:0];
        end
    endfunction

    // an error flag drops the packet unless its pass bit is set
    function err_drop;
        input err;
        input pass_bit;
        begin
            err_drop = err && !pass_bit;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // storage

    reg  [7:0] port_sel_q;
    reg  [7:0] alias_q  [0:11];
    reg  [6:0] tid_q    [0:11];
    reg  [7:0] cfg_q    [0:3];
    reg  [2:0] st_q     [0:3];
    reg  [2:0] strap_s1_q;
    reg  [2:0] strap_s2_q;
    reg        strap_done_q;

    wire [1:0] sel_port = port_sel_q[1:0];
    integer    i;

    reg  [1:0] ent_d;
    reg        ent_ok_d;
    always @* begin
        ent_ok_d = 1'b1;
        case (i_reg_addr)
            `RPA_ALIAS5_ADDR, `RPA_TID5_ADDR: ent_d = 2'd0;
            `RPA_ALIAS6_ADDR, `RPA_TID6_ADDR: ent_d = 2'd1;
            `RPA_ALIAS7_ADDR, `RPA_TID7_ADDR: ent_d = 2'd2;
            default: begin
                ent_d    = 2'd0;
                ent_ok_d = 1'b0;
            end
        endcase
    end
    wire [3:0] ent_idx   = ent_index(sel_port, ent_d);
    wire       is_alias  = (i_reg_addr == `RPA_ALIAS5_ADDR) ||
                           (i_reg_addr == `RPA_ALIAS6_ADDR) ||
                           (i_reg_addr == `RPA_ALIAS7_ADDR);

    // strap pins pass two flops; no reset so they are settled at release
    always @(posedge i_clk) begin
        strap_s1_q <= i_strap;
        strap_s2_q <= strap_s1_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes and per-port packet state

    reg  [7:0] pcfg;
    reg        pass_d;
    reg  [2:0] st_d;
    always @* begin
        pcfg   = cfg_q[i_pkt_port];
        st_d   = st_q[i_pkt_port];
        pass_d = 1'b0;
        if (is_raw(pcfg[1:0])) begin
            // frame gating and checksum are meaningless for raw pixel input
            pass_d = !(i_pkt_short_line && pcfg[`RPA_CFG_LINE_LEN]) &&
                     !err_drop(i_pkt_ecc_err, pcfg[`RPA_CFG_PASS_ECC]);
        end else begin
            // an accepted frame start is passed on itself
            case (st_q[i_pkt_port])
                ST_WAIT_FS1: begin
                    if (i_pkt_fs && i_pkt_frame_cnt == `RPA_FIRST_FRAME_CNT) begin
                        st_d   = ST_RUN;
                        pass_d = 1'b1;
                    end
                end
                ST_WAIT_FS: begin
                    if (i_pkt_fs) begin
                        st_d   = ST_RUN;
                        pass_d = 1'b1;
                    end
                end
                ST_RUN: begin
                    pass_d = 1'b1;
                end
                default: begin
                    st_d = ST_RUN;
                end
            endcase
            if (err_drop(i_pkt_cksum_err, pcfg[`RPA_CFG_PASS_CKSUM])) begin
                pass_d = 1'b0;
            end
            if (err_drop(i_pkt_ecc_err, pcfg[`RPA_CFG_PASS_ECC])) begin
                pass_d = 1'b0;
            end
            if (err_drop(i_pkt_len_err, pcfg[`RPA_CFG_LINE_LEN])) begin
                pass_d = 1'b0;
            end
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            port_sel_q   <= `RPA_PORT_SEL_RST;
            strap_done_q <= 1'b0;
            o_pkt_valid  <= 1'b0;
            o_pkt_port   <= 2'd0;
            o_pkt_pass   <= 1'b0;
            for (i = 0; i < 12; i = i + 1) begin
                alias_q[i] <= `RPA_ALIAS_RST;
                tid_q[i]   <= `RPA_TID_RST;
            end
            for (i = 0; i < 4; i = i + 1) begin
                cfg_q[i] <= {`RPA_CFG_HI_RST, 3'b000};
                st_q[i]  <= ST_WAIT_FS;
            end
        end else begin
            o_pkt_valid <= i_pkt_valid;
            o_pkt_port  <= i_pkt_port;
            o_pkt_pass  <= i_pkt_valid & pass_d;
            if (i_pkt_valid) begin
                st_q[i_pkt_port] <= st_d;
            end
            if (!strap_done_q) begin
                // straps land once, at the first edge after release
                // a register write in this cycle is dropped
                strap_done_q <= 1'b1;
                for (i = 0; i < 4; i = i + 1) begin
                    cfg_q[i] <= {`RPA_CFG_HI_RST, strap_s2_q};
                    st_q[i]  <= arm_state({`RPA_CFG_HI_RST, strap_s2_q});
                end
            end else if (i_reg_wr) begin
                if (i_reg_addr == `RPA_PORT_SEL_ADDR) begin
                    port_sel_q <= i_reg_wdata;
                end else if (i_reg_addr == `RPA_CFG_ADDR) begin
                    cfg_q[sel_port] <= i_reg_wdata;
                    // a config write re-arms the frame-start wait of that port
                    st_q[sel_port]  <= arm_state(i_reg_wdata);
                end else if (ent_ok_d && is_alias) begin
                    alias_q[ent_idx] <= i_reg_wdata;
                end else if (ent_ok_d) begin
                    tid_q[ent_idx] <= i_reg_wdata[7:1];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register reads

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            if (i_reg_addr == `RPA_PORT_SEL_ADDR) begin
                o_reg_rdata <= port_sel_q;
            end else if (i_reg_addr == `RPA_CFG_ADDR) begin
                o_reg_rdata <= cfg_q[sel_port];
            end else if (ent_ok_d && is_alias) begin
                o_reg_rdata <= alias_q[ent_idx];
            end else if (ent_ok_d) begin
                o_reg_rdata <= {tid_q[ent_idx], 1'b0};
            end else begin
                // unmapped offsets read as zero
                o_reg_rdata <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alias decoder: lowest port, then lowest entry, wins

    reg        hit_d;
    reg  [1:0] hit_port_d;
    reg  [6:0] hit_addr_d;
    reg        hit_ack_d;
    integer    k;
    always @* begin
        hit_d      = 1'b0;
        hit_port_d = 2'd0;
        hit_addr_d = 7'h00;
        hit_ack_d  = 1'b0;
        for (k = 11; k >= 0; k = k - 1) begin
            if (alias_q[k][7:1] != 7'h00 &&
                alias_q[k][7:1] == i_txn_addr) begin
                hit_d      = 1'b1;
                hit_port_d = ent_port(k);
                hit_addr_d = tid_q[k];
                hit_ack_d  = alias_q[k][`RPA_ALIAS_AUTO_ACK] & i_txn_write;
            end
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_fwd_valid    <= 1'b0;
            o_fwd_hit      <= 1'b0;
            o_fwd_port     <= 2'd0;
            o_fwd_addr     <= 7'h00;
            o_fwd_auto_ack <= 1'b0;
        end else begin
            o_fwd_valid    <= i_txn_valid;
            // only a valid request raises hit; port and addr follow the bus
            o_fwd_hit      <= i_txn_valid & hit_d;
            o_fwd_port     <= hit_port_d;
            o_fwd_addr     <= hit_d ? hit_addr_d : i_txn_addr;
            o_fwd_auto_ack <= i_txn_valid & hit_d & hit_ack_d;
        end
    end

endmodule // rpa_port_cfg

//--- dv/rpa_port_cfg_checker.sv
`timescale 1ns/1ns
module rpa_port_cfg_checker (
    input wire       i_clk,          // clock
    input wire       i_rst_n,        // reset
    input wire       i_reg_rd,       // read strobe
    input wire [7:0] i_reg_addr,     // offset
    input wire [7:0] o_reg_rdata,    // read data
    input wire       i_txn_valid,    // decode request
    input wire [6:0] i_txn_addr,     // request address
    input wire       i_txn_write,    // request is write
    input wire       o_fwd_valid,    // decode answer
    input wire       o_fwd_hit,      // alias hit
    input wire [1:0] o_fwd_port,     // hit port
    input wire [6:0] o_fwd_addr,     // forwarded address
    input wire       o_fwd_auto_ack, // local ack
    input wire       i_pkt_valid,    // packet in
    input wire [1:0] i_pkt_port,     // packet port
    input wire       o_pkt_valid,    // verdict
    input wire [1:0] o_pkt_port,     // verdict port
    input wire       o_pkt_pass      // forwarded
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////////////////
    fwd_pulse_a: assert property (i_txn_valid |=> o_fwd_valid)
        else $error("decode answer missing");
    fwd_idle_a: assert property (!i_txn_valid |=> !o_fwd_valid && !o_fwd_hit)
        else $error("decode answer without request");
    auto_ack_a: assert property (o_fwd_auto_ack |-> o_fwd_hit && $past(i_txn_write))
        else $error("local ack without write hit");
    miss_pass_a: assert property (o_fwd_valid && !o_fwd_hit |->
        o_fwd_addr == $past(i_txn_addr) && o_fwd_port == 2'h0)
        else $error("miss changed the address");
    zero_alias_a: assert property (i_txn_valid && i_txn_addr == 7'h00 |=> !o_fwd_hit)
        else $error("zero address matched");
    pkt_pulse_a: assert property (i_pkt_valid |=>
        o_pkt_valid && o_pkt_port == $past(i_pkt_port))
        else $error("packet verdict missing");
    pkt_idle_a: assert property (!i_pkt_valid |=> !o_pkt_valid && !o_pkt_pass)
        else $error("verdict without packet");
    rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data moved without read");
    unmapped_rd_a: assert property (i_reg_rd && i_reg_addr == 8'h00 |=>
        o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    ////////////////////////////////////////////////////////////////////////////
    cover property (o_fwd_hit && o_fwd_auto_ack);
    cover property (o_pkt_valid && !o_pkt_pass);
    cover property (o_fwd_valid && !o_fwd_hit);
    cover property (o_pkt_valid && o_pkt_pass);
endmodule // rpa_port_cfg_checker

bind rpa_port_cfg rpa_port_cfg_checker rpa_port_cfg_checker_inst (
    .i_clk, .i_rst_n, .i_reg_rd, .i_reg_addr, .o_reg_rdata, .i_txn_valid,
    .i_txn_addr, .i_txn_write, .o_fwd_valid, .o_fwd_hit, .o_fwd_port, .o_fwd_addr,
    .o_fwd_auto_ack, .i_pkt_valid, .i_pkt_port, .o_pkt_valid, .o_pkt_port, .o_pkt_pass
);

//--- dv/rpa_host_model.sv
`timescale 1ns/1ns
module rpa_host_model (
    input  wire       i_clk,       // clock
    output reg        o_wr,        // write strobe
    output reg        o_rd,        // read strobe
    output reg  [7:0] o_addr,      // offset
    output reg  [7:0] o_wdata,     // write data
    input  wire [7:0] i_rdata,     // read data
    output reg        o_txn_valid, // decode request
    output reg  [6:0] o_txn_addr,  // target address
    output reg        o_txn_write  // write flag
);
    initial begin
        {o_wr, o_rd, o_addr, o_wdata} = 18'h00000;
        {o_txn_valid, o_txn_addr, o_txn_write} = 9'h000;
    end
    // strobes rise and fall on falling edges; the address is scrambled once released
    task wr(input [7:0] a, input [7:0] d); begin
        @(negedge i_clk);
        {o_wr, o_addr, o_wdata} = {1'b1, a, d};
        @(negedge i_clk);
        {o_wr, o_addr} = {1'b0, ~a};
    end endtask
    task rd(input [7:0] a, output [7:0] d); begin
        @(negedge i_clk);
        {o_rd, o_addr} = {1'b1, a};
        @(negedge i_clk);
        {o_rd, o_addr} = {1'b0, ~a};
        d = i_rdata;
    end endtask
    task txn(input [6:0] a, input w); begin
        @(negedge i_clk);
        {o_txn_valid, o_txn_addr, o_txn_write} = {1'b1, a, w};
        @(negedge i_clk);
        {o_txn_valid, o_txn_addr} = {1'b0, ~a};
    end endtask
endmodule // rpa_host_model

//--- dv/rpa_port_cfg_tb.sv
`timescale 1ns/1ns
module rpa_port_cfg_tb;
    reg         i_clk, i_rst_n, i_pkt_valid, i_pkt_fs;
    reg         i_pkt_cksum_err, i_pkt_ecc_err, i_pkt_len_err, i_pkt_short_line;
    reg  [2:0]  i_strap;
    reg  [1:0]  i_pkt_port;
    reg  [15:0] i_pkt_frame_cnt;
    wire        i_reg_wr, i_reg_rd, i_txn_valid, i_txn_write;
    wire [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata;
    wire [6:0]  i_txn_addr, o_fwd_addr;
    wire        o_fwd_valid, o_fwd_hit, o_fwd_auto_ack, o_pkt_valid, o_pkt_pass;
    wire [1:0]  o_fwd_port, o_pkt_port;
    integer     miscompares, compares, m;

    rpa_port_cfg rpa_port_cfg_inst (.i_clk, .i_rst_n, .i_strap, .i_reg_wr, .i_reg_rd,
        .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_txn_valid, .i_txn_addr, .i_txn_write,
        .o_fwd_valid, .o_fwd_hit, .o_fwd_port, .o_fwd_addr, .o_fwd_auto_ack, .i_pkt_valid,
        .i_pkt_port, .i_pkt_fs, .i_pkt_frame_cnt, .i_pkt_cksum_err, .i_pkt_ecc_err,
        .i_pkt_len_err, .i_pkt_short_line, .o_pkt_valid, .o_pkt_port, .o_pkt_pass);
    rpa_host_model rpa_host_model_inst (.i_clk, .o_wr(i_reg_wr), .o_rd(i_reg_rd),
        .o_addr(i_reg_addr), .o_wdata(i_reg_wdata), .i_rdata(o_reg_rdata),
        .o_txn_valid(i_txn_valid), .o_txn_addr(i_txn_addr), .o_txn_write(i_txn_write));
    ////////////////////////////////////////////////////////////////////////////
    task chk(input [15:0] s, input [15:0] e); begin
        compares = compares + 1;
        if (s !== e) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: saw %h expected %h", $time, s, e);
        end
    end endtask
    task tally_and_finish; begin
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end endtask
    task pw(input [1:0] p, input [7:0] a, input [7:0] d); begin
        rpa_host_model_inst.wr(8'h4c, {6'h00, p});
        rpa_host_model_inst.wr(a, d);
    end endtask
    task pr(input [1:0] p, input [7:0] a, input [7:0] e);
        reg [7:0] d;
        begin
            rpa_host_model_inst.wr(8'h4c, {6'h00, p});
            rpa_host_model_inst.rd(a, d);
            chk({8'h00, d}, {8'h00, e});
        end
    endtask
    // expected fields: hit, port, forwarded address, local ack
    task tx(input [6:0] a, input w, input [10:0] e); begin
        rpa_host_model_inst.txn(a, w);
        chk({4'h0, o_fwd_valid, o_fwd_hit, o_fwd_port, o_fwd_addr, o_fwd_auto_ack},
            {4'h0, 1'b1, e});
    end endtask
    // error flags: checksum, header ecc, length, short first line
    task pk(input [1:0] p, input f, input [15:0] c, input [3:0] er, input x); begin
        @(negedge i_clk);
        {i_pkt_valid, i_pkt_port, i_pkt_fs, i_pkt_frame_cnt} = {1'b1, p, f, c};
        {i_pkt_cksum_err, i_pkt_ecc_err, i_pkt_len_err, i_pkt_short_line} = er;
        @(negedge i_clk);
        i_pkt_valid = 1'b0;
        chk({12'h000, o_pkt_valid, o_pkt_port, o_pkt_pass}, {12'h000, 1'b1, p, x});
    end endtask
    ////////////////////////////////////////////////////////////////////////////
    task t_reset; begin
        pr(2'd0, 8'h6d, 8'h7d);
        pr(2'd3, 8'h6a, 8'h00);
        pr(2'd1, 8'h00, 8'h00);
        pk(2'd3, 1'b0, 16'h0000, 4'b0001, 1'b0);
        $display("reset test done");
    end endtask
    task t_ports; begin
        pw(2'd1, 8'h6a, 8'h66);
        pr(2'd0, 8'h6a, 8'h00);
        pr(2'd1, 8'h6a, 8'h66);
        $display("port test done");
    end endtask
    task t_alias; begin
        pw(2'd1, 8'h6b, {7'h2a, 1'b1});
        pw(2'd1, 8'h63, {7'h11, 1'b0});
        pw(2'd0, 8'h6a, 8'h01);
        tx(7'h2a, 1'b1, {1'b1, 2'd1, 7'h11, 1'b1});
        tx(7'h2a, 1'b0, {1'b1, 2'd1, 7'h11, 1'b0});
        tx(7'h33, 1'b1, {1'b1, 2'd1, 7'h00, 1'b0});
        tx(7'h00, 1'b1, {1'b0, 2'd0, 7'h00, 1'b0});
        tx(7'h3c, 1'b1, {1'b0, 2'd0, 7'h3c, 1'b0});
        $display("alias test done");
    end endtask
    task t_csi; begin
        pw(2'd0, 8'h6d, 8'h80);
        pk(2'd0, 1'b1, 16'h0002, 4'b0000, 1'b0);
        pk(2'd0, 1'b0, 16'h0000, 4'b0000, 1'b0);
        pk(2'd0, 1'b1, 16'h0001, 4'b0000, 1'b1);
        pk(2'd0, 1'b0, 16'h0000, 4'b1000, 1'b0);
        pk(2'd0, 1'b0, 16'h0000, 4'b0100, 1'b0);
        pk(2'd0, 1'b0, 16'h0000, 4'b0010, 1'b0);
        pw(2'd0, 8'h6d, 8'h78);
        pk(2'd0, 1'b0, 16'h0000, 4'b0000, 1'b0);
        pk(2'd0, 1'b1, 16'h0005, 4'b0000, 1'b1);
        pk(2'd0, 1'b0, 16'h0000, 4'b1110, 1'b1);
        $display("csi test done");
    end endtask
    task t_raw; begin
        for (m = 1; m < 4; m = m + 1) begin
            pw(2'd2, 8'h6d, {6'h30, m[1:0]});
            pk(2'd2, 1'b0, 16'h0000, 4'b1000, 1'b1);
            pk(2'd2, 1'b0, 16'h0000, 4'b0001, 1'b1);
            pk(2'd2, 1'b0, 16'h0000, 4'b0100, 1'b0);
            pw(2'd2, 8'h6d, {6'h32, m[1:0]});
            pk(2'd2, 1'b0, 16'h0000, 4'b0001, 1'b0);
        end
        $display("raw test done");
    end endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    initial begin
        {i_rst_n, i_strap, miscompares, compares} = {1'b0, 3'b101, 32'd0, 32'd0};
        {i_pkt_valid, i_pkt_port, i_pkt_fs, i_pkt_frame_cnt} = 20'h00000;
        {i_pkt_cksum_err, i_pkt_ecc_err, i_pkt_len_err, i_pkt_short_line} = 4'h0;
        repeat (8) @(negedge i_clk);
        i_rst_n = 1'b1;
        @(negedge i_clk);
        t_reset;
        t_ports;
        t_alias;
        t_csi;
        t_raw;
        tally_and_finish;
    end
    initial begin
        #400000;
        miscompares = miscompares + 1;
        tally_and_finish;
    end
endmodule // rpa_port_cfg_tb
